// File: rtl/smp_defines.vh
/*
 * Constants for the synchronous memory port controller: widths, state codes,
 * setting encodings and reset levels of the pins.
 * Assumes inclusion by bare name from the design file; definitions only.
 */
`ifndef SMP_DEFINES_VH
`define SMP_DEFINES_VH

// data path and address widths
`define SMP_DW            32
`define SMP_AW            20
`define SMP_BW            4

// sequencer states
`define SMP_ST_IDLE       2'h0
`define SMP_ST_ISSUE      2'h1
`define SMP_ST_LAT        2'h2
`define SMP_ST_DESEL      2'h3

// setting encodings
`define SMP_CLKSEL_ONE    1'h0
`define SMP_CHIP_SELECT_EXTEND_STD     1'h0
`define SMP_CHIP_SELECT_EXTEND_FIFO    1'h1
`define SMP_READ_ENABLE_MODE_ADS     1'h0
`define SMP_READ_ENABLE_MODE_RE      1'h1

// phase counter width and first phase
`define SMP_PW            3
`define SMP_PHASE_CMD     3'h0

// strobe pins idle high
`define SMP_PIN_IDLE      1'h1
`endif

// File: rtl/smp_ctrl.v
/*
 * Synchronous memory port controller: one request at a time is run against
 * burst SRAM, zero-turnaround SRAM or a synchronous FIFO over shared strobe
 * pins, paced by one of two interface clocks.
 * Assumes the interface clocks come from elsewhere and are slower than
 * mclk/2; settings are steady while a request is offered.
 */
`timescale 1ns/100ps
`include "smp_defines.vh"

// Notes on behaviour
// - read latency zero to three interface cycles
// - write latency zero to three interface cycles
// - extend off: chip select drops after command
// - extend on: chip select follows output enable
// - mode zero: address strobe plus deselect cycle
// - mode one: read enable, no deselect cycle
// - pins paced by chosen interface clock
// - three strobe pins: strobe, output, write enable
// - sdram clock enable on first port only
// - peripheral strobes on clock one; sdram clock enable passed through every mclk
// - peripheral mode: no capture, data undriven
// - peripheral strobe delay zero to three cycles
module smp_ctrl #(
    parameter FIRST_PORT = 1
) (
    // clock and reset
    input  wire                    mclk,
    input  wire                    rst_b,
    // interface clocks from the clock generator
    input  wire                    interface_clock_one,
    input  wire                    interface_clock_two,
    // settings
    input  wire [1:0]              sync_read_latency,
    input  wire [1:0]              sync_write_latency,
    input  wire                    chip_select_extend,
    input  wire                    read_enable_mode,
    input  wire                    sync_clock_select,
    input  wire [1:0]              peripheral_read_delay,
    input  wire [1:0]              peripheral_write_delay,
    input  wire                    sdram_clock_enable_req,
    // request side
    input  wire                    req_valid,
    output reg                     req_ready_r,
    input  wire                    req_write,
    input  wire                    req_periph,
    input  wire [`SMP_AW-1:0]      req_addr,
    input  wire [`SMP_BW-1:0]      req_be,
    input  wire [`SMP_DW-1:0]      req_wdata,
    // read data side
    output reg                     rd_valid_r,
    input  wire                    rd_ready,
    output reg  [`SMP_DW-1:0]      rd_data_r,
    // status
    output reg                     busy_r,
    // memory pins
    output reg                     chip_select_n_r,
    output reg                     strobe_ads_re_n_r,
    output reg                     sync_output_enable_n_r,
    output reg                     sync_write_enable_n_r,
    output reg  [`SMP_AW-1:0]      mem_addr_r,
    output reg  [`SMP_BW-1:0]      mem_be_n_r,
    output reg  [`SMP_DW-1:0]      mem_data_out_r,
    output reg                     mem_data_oe_r,
    input  wire [`SMP_DW-1:0]      mem_data_in,
    output reg                     peripheral_transfer_strobe_r,
    output reg                     sdram_clock_enable_r
);

    // synchronisers for clocks and read data; first stages read only by second
    reg                  clk1_m_r;
    reg                  clk1_s_r;
    reg                  clk1_d_r;
    reg                  clk2_m_r;
    reg                  clk2_s_r;
    reg                  clk2_d_r;
    reg [`SMP_DW-1:0]    din_m_r;
    reg [`SMP_DW-1:0]    din_s_r;

    // latched request
    reg [1:0]            state_r;
    reg [1:0]            state_nxt;
    reg [`SMP_PW-1:0]    cnt_r;
    reg                  wr_r;
    reg                  pdt_r;
    reg [1:0]            lat_r;
    reg [1:0]            dly_r;
    reg                  ext_r;
    reg                  ren_r;
    reg                  csel_r;
    reg [`SMP_AW-1:0]    addr_r;
    reg [`SMP_BW-1:0]    be_r;
    reg [`SMP_DW-1:0]    wdata_r;

    // spare entry of the two-entry read buffer
    reg                  spare_v_r;
    reg [`SMP_DW-1:0]    spare_d_r;

    wire                 tick1;
    wire                 tick2;
    wire                 tick;
    wire [`SMP_PW-1:0]   last;
    wire [`SMP_PW-1:0]   phase;
    wire                 active;
    wire                 capture;
    wire                 accept;
    wire                 pop;
    reg                  spare_v_nxt;

    // widen a two-bit setting to the phase counter width
    function [`SMP_PW-1:0] widen;
        input [1:0] v;
        begin
            widen = {1'h0, v};
        end
    endfunction

    // two-flop sampling of interface clocks and read data bus
    always @(posedge mclk)
    begin
        if (!rst_b)
        begin
            clk1_m_r <= 1'h0;
            clk1_s_r <= 1'h0;
            clk1_d_r <= 1'h0;
            clk2_m_r <= 1'h0;
            clk2_s_r <= 1'h0;
            clk2_d_r <= 1'h0;
            din_m_r  <= {`SMP_DW{1'h0}};
            din_s_r  <= {`SMP_DW{1'h0}};
        end
        else
        begin
            clk1_m_r <= interface_clock_one;
            clk1_s_r <= clk1_m_r;
            clk1_d_r <= clk1_s_r;
            clk2_m_r <= interface_clock_two;
            clk2_s_r <= clk2_m_r;
            clk2_d_r <= clk2_s_r;
            din_m_r  <= mem_data_in;
            din_s_r  <= din_m_r;
        end
    end

    // rising edges of each interface clock, seen in the mclk domain
    assign tick1 = clk1_s_r & ~clk1_d_r;
    assign tick2 = clk2_s_r & ~clk2_d_r;
    // peripheral transfers always pace on clock one
    assign tick = (pdt_r | (csel_r == `SMP_CLKSEL_ONE)) ? tick1 : tick2;

    // last phase: data phase plus any peripheral strobe delay
    assign last   = widen(lat_r) + (pdt_r ? widen(dly_r) : `SMP_PHASE_CMD);
    assign phase  = (state_r == `SMP_ST_ISSUE) ? `SMP_PHASE_CMD : cnt_r + 3'h1;
    assign active = (state_r == `SMP_ST_ISSUE) |
                    ((state_r == `SMP_ST_LAT) & (cnt_r < last));
    // read data sampled at the end of the data phase, never in peripheral mode
    assign capture = tick & (state_r == `SMP_ST_LAT) & ~wr_r & ~pdt_r &
                     (cnt_r == widen(lat_r));
    assign accept  = req_valid & req_ready_r;
    assign pop     = rd_valid_r & rd_ready;

    // sequencer next state; deselect cycle only in address strobe mode
    always @*
    begin
        state_nxt = state_r;
        case (state_r)
            `SMP_ST_IDLE:
            begin
                if (accept)
                    state_nxt = `SMP_ST_ISSUE;
            end
            `SMP_ST_ISSUE:
            begin
                if (tick)
                    state_nxt = `SMP_ST_LAT;
            end
            `SMP_ST_LAT:
            begin
                if (tick && (cnt_r == last))
                    state_nxt = (ren_r == `SMP_READ_ENABLE_MODE_ADS) ? `SMP_ST_DESEL :
                                `SMP_ST_IDLE;
            end
            `SMP_ST_DESEL:
            begin
                if (tick)
                    state_nxt = `SMP_ST_IDLE;
            end
            default:
            begin
                state_nxt = `SMP_ST_IDLE;
            end
        endcase
    end

    // spare entry occupancy after this cycle's push and pop
    always @*
    begin
        spare_v_nxt = spare_v_r;
        if (pop)
            spare_v_nxt = spare_v_r & capture;
        else if (capture && rd_valid_r)
            spare_v_nxt = 1'h1;
    end

    // request latch and phase counter
    always @(posedge mclk)
    begin
        if (!rst_b)
        begin
            state_r <= `SMP_ST_IDLE;
            cnt_r   <= `SMP_PHASE_CMD;
            wr_r    <= 1'h0;
            pdt_r   <= 1'h0;
            lat_r   <= 2'h0;
            dly_r   <= 2'h0;
            ext_r   <= `SMP_CHIP_SELECT_EXTEND_STD;
            ren_r   <= `SMP_READ_ENABLE_MODE_ADS;
            csel_r  <= `SMP_CLKSEL_ONE;
            addr_r  <= {`SMP_AW{1'h0}};
            be_r    <= {`SMP_BW{1'h0}};
            wdata_r <= {`SMP_DW{1'h0}};
        end
        else
        begin
            state_r <= state_nxt;
            if (accept)
            begin
                wr_r    <= req_write;
                pdt_r   <= req_periph;
                // settings captured per access so they hold for its length
                lat_r   <= req_write ? sync_write_latency : sync_read_latency;
                dly_r   <= req_write ? peripheral_write_delay : peripheral_read_delay;
                ext_r   <= chip_select_extend;
                ren_r   <= read_enable_mode;
                csel_r  <= sync_clock_select;
                addr_r  <= req_addr;
                be_r    <= req_be;
                wdata_r <= req_wdata;
            end
            if (tick && active)
                cnt_r <= phase;
        end
    end

    // pin launch on the pacing clock edge; strobes idle outside phases, address and byte enables hold
    always @(posedge mclk)
    begin
        if (!rst_b)
        begin
            chip_select_n_r              <= `SMP_PIN_IDLE;
            strobe_ads_re_n_r            <= `SMP_PIN_IDLE;
            sync_output_enable_n_r       <= `SMP_PIN_IDLE;
            sync_write_enable_n_r        <= `SMP_PIN_IDLE;
            mem_addr_r                   <= {`SMP_AW{1'h0}};
            mem_be_n_r                   <= {`SMP_BW{1'h1}};
            mem_data_out_r               <= {`SMP_DW{1'h0}};
            mem_data_oe_r                <= 1'h0;
            peripheral_transfer_strobe_r <= 1'h0;
        end
        else if (tick)
        begin
            if (active)
            begin
                // command in phase zero on the three shared strobes
                strobe_ads_re_n_r     <= (phase != `SMP_PHASE_CMD);
                sync_write_enable_n_r <= ~(wr_r & (phase == `SMP_PHASE_CMD));
                sync_output_enable_n_r <= ~(~wr_r & (phase <= widen(lat_r)));
                // extended select rides with output enable for FIFO glue
                chip_select_n_r <= ~((phase == `SMP_PHASE_CMD) |
                                     (ext_r & ~wr_r & (phase <= widen(lat_r))));
                mem_addr_r      <= addr_r;
                mem_be_n_r      <= ~be_r;
                mem_data_out_r  <= wdata_r;
                // write data in its latency phase; bus left alone for peripheral
                mem_data_oe_r   <= wr_r & ~pdt_r & (phase == widen(lat_r));
                peripheral_transfer_strobe_r <= pdt_r & (phase == last);
            end
            else
            begin
                // deselect or idle: every strobe released
                chip_select_n_r              <= `SMP_PIN_IDLE;
                strobe_ads_re_n_r            <= `SMP_PIN_IDLE;
                sync_output_enable_n_r       <= `SMP_PIN_IDLE;
                sync_write_enable_n_r        <= `SMP_PIN_IDLE;
                mem_data_oe_r                <= 1'h0;
                peripheral_transfer_strobe_r <= 1'h0;
            end
        end
    end

    // two-entry read buffer: output stage plus spare, so a stall loses nothing
    always @(posedge mclk)
    begin
        if (!rst_b)
        begin
            rd_valid_r <= 1'h0;
            rd_data_r  <= {`SMP_DW{1'h0}};
            spare_v_r  <= 1'h0;
            spare_d_r  <= {`SMP_DW{1'h0}};
        end
        else
        begin
            spare_v_r <= spare_v_nxt;
            if (capture && rd_valid_r && !pop)
                spare_d_r <= din_s_r;
            if (pop)
            begin
                rd_valid_r <= spare_v_r | capture;
                rd_data_r  <= spare_v_r ? spare_d_r : din_s_r;
                if (spare_v_r && capture)
                    spare_d_r <= din_s_r;
            end
            else if (capture && !rd_valid_r)
            begin
                rd_valid_r <= 1'h1;
                rd_data_r  <= din_s_r;
            end
        end
    end

    // handshake, status and sdram clock enable outputs
    always @(posedge mclk)
    begin
        if (!rst_b)
        begin
            req_ready_r          <= 1'h0;
            busy_r               <= 1'h0;
            sdram_clock_enable_r <= 1'h0;
        end
        else
        begin
            // one access at a time, only while the spare entry is free
            req_ready_r <= (state_nxt == `SMP_ST_IDLE) & ~accept & ~spare_v_nxt;
            busy_r      <= (state_nxt != `SMP_ST_IDLE);
            // second port keeps this pin low, it has no such output
            if (FIRST_PORT != 0)
                sdram_clock_enable_r <= sdram_clock_enable_req;
        end
    end

endmodule

// File: tb/smp_ctrl_monitor.sv
/* Checker for the synchronous memory port: pin timing against the settings held at request time.
   Assumes interface clocks of eight mclk periods, as the bench makes them. */
`timescale 1ns/100ps
module smp_ctrl_monitor #(
    parameter FIRST_PORT = 1
) (
    // clock and reset
    input wire       mclk,
    input wire       rst_b,
    // settings and request
    input wire [1:0] sync_read_latency,
    input wire [1:0] sync_write_latency,
    input wire       chip_select_extend,
    input wire       read_enable_mode,
    input wire       sdram_clock_enable_req,
    input wire       req_valid,
    input wire       req_ready_r,
    input wire       req_write,
    input wire       req_periph,
    input wire [1:0] peripheral_read_delay,
    input wire [1:0] peripheral_write_delay,
    input wire [3:0] req_be,
    // pins
    input wire       chip_select_n_r,
    input wire       strobe_ads_re_n_r,
    input wire       sync_output_enable_n_r,
    input wire       sync_write_enable_n_r,
    input wire       mem_data_oe_r,
    input wire [3:0] mem_be_n_r,
    input wire       busy_r,
    input wire       peripheral_transfer_strobe_r,
    input wire       sdram_clock_enable_r
);
    reg [1:0] rl_r, wl_r;
    reg       ext_r, mode_r, wr_r, per_r;
    reg [7:0] cnt_r;
    reg [1:0] dl_r;
    reg [3:0] be_r;
    // data phase and peripheral strobe delay of the access in flight, in phases
    wire [7:0] lat_w = {6'h00, wr_r ? wl_r : rl_r};
    wire [7:0] dly_w = per_r ? {6'h00, dl_r} : 8'h00;
    default clocking dck @(posedge mclk);
    endclocking
    default disable iff (!rst_b);

    // settings of the access in flight, taken at the accepting edge
    always @(posedge mclk)
        if (req_valid && req_ready_r)
            {rl_r, wl_r, ext_r, mode_r, wr_r, per_r} <= {sync_read_latency, sync_write_latency,
                chip_select_extend, read_enable_mode, req_write, req_periph};
    always @(posedge mclk)
        if (req_valid && req_ready_r)
            {dl_r, be_r} <= {req_write ? peripheral_write_delay : peripheral_read_delay, req_be};

    // cycles since chip select fell; saturates so a long idle cannot wrap
    always @(posedge mclk)
        if (!rst_b)
            cnt_r <= 8'h00;
        else if ($fell(chip_select_n_r))
            cnt_r <= 8'h01;
        else if (cnt_r != 8'hFF)
            cnt_r <= cnt_r + 8'h01;

    chk_write_latency: assert property ($rose(mem_data_oe_r) |->
        ($fell(chip_select_n_r) ? 8'h00 : cnt_r) == 8'h08 * {6'h00, wl_r}) else $error("bad wr lat");
    chk_read_latency: assert property ($rose(sync_output_enable_n_r) |->
        cnt_r == 8'h08 * ({6'h00, rl_r} + 8'h01)) else $error("bad rd lat");
    chk_cs_std_drop: assert property (!ext_r && !chip_select_n_r |-> !strobe_ads_re_n_r)
        else $error("select past command");
    chk_cs_follow_oe: assert property (ext_r && !wr_r && !per_r && !sync_output_enable_n_r
        |-> !chip_select_n_r) else $error("select not held");
    chk_ads_with_cs: assert property (!mode_r && !strobe_ads_re_n_r |-> !chip_select_n_r)
        else $error("strobe without select");
    chk_we_on_write: assert property (!sync_write_enable_n_r |-> wr_r)
        else $error("write enable on read");
    chk_pdt_periph: assert property (peripheral_transfer_strobe_r |-> per_r)
        else $error("stray transfer strobe");
    chk_cke_pass: assert property ($past(rst_b) |-> sdram_clock_enable_r ==
        ((FIRST_PORT != 0) && $past(sdram_clock_enable_req))) else $error("bad clock enable");
    chk_pdt_delay: assert property ($rose(peripheral_transfer_strobe_r) |->
        ($fell(chip_select_n_r) ? 8'h00 : cnt_r) == 8'h08 * (lat_w + dly_w))
        else $error("bad strobe delay");
    // mode zero keeps the port busy one extra phase for the deselect cycle
    chk_deselect_gap: assert property ($fell(busy_r) |->
        cnt_r == 8'h08 * (lat_w + dly_w + (mode_r ? 8'h01 : 8'h02))) else $error("bad deselect");
    chk_be_pins: assert property (!chip_select_n_r |-> mem_be_n_r == ~be_r)
        else $error("bad byte enables");
endmodule

bind smp_ctrl smp_ctrl_monitor #(.FIRST_PORT(FIRST_PORT)) u_smp_mon (
    .mclk(mclk), .rst_b(rst_b), .sync_read_latency(sync_read_latency),
    .sync_write_latency(sync_write_latency), .chip_select_extend(chip_select_extend),
    .read_enable_mode(read_enable_mode), .sdram_clock_enable_req(sdram_clock_enable_req),
    .req_valid(req_valid), .req_ready_r(req_ready_r), .req_write(req_write),
    .req_periph(req_periph), .chip_select_n_r(chip_select_n_r),
    .strobe_ads_re_n_r(strobe_ads_re_n_r), .sync_output_enable_n_r(sync_output_enable_n_r),
    .sync_write_enable_n_r(sync_write_enable_n_r), .mem_data_oe_r(mem_data_oe_r),
    .peripheral_transfer_strobe_r(peripheral_transfer_strobe_r),
    .sdram_clock_enable_r(sdram_clock_enable_r), .busy_r(busy_r), .req_be(req_be),
    .mem_be_n_r(mem_be_n_r), .peripheral_read_delay(peripheral_read_delay),
    .peripheral_write_delay(peripheral_write_delay));

// File: tb/smp_mem_model.sv
/* Sixteen-word synchronous memory behind the strobe pins.
   Assumes the controller holds address and data for whole phases. */
`timescale 1ns/100ps
`include "smp_defines.vh"
module smp_mem_model (
    // clock
    input wire               mclk,
    // pins from the controller
    input wire               chip_select_n,
    input wire               output_enable_n,
    input wire               data_oe,
    input wire [`SMP_AW-1:0] addr,
    input wire [`SMP_DW-1:0] wdata,
    // read data back
    output reg [`SMP_DW-1:0] rdata
);
    reg [`SMP_DW-1:0] mem_r [0:15];
    reg [3:0]         adr_r;
    initial rdata = 32'h0000_0000;
    // address taken while selected; at latency zero select and data share a phase,
    // so the live address wins over the one held from an earlier access
    always @(posedge mclk)
    begin
        if (!chip_select_n)
            adr_r <= addr[3:0];
        if (data_oe)
            mem_r[!chip_select_n ? addr[3:0] : adr_r] <= wdata;
        // released bus toggles so a late capture never sees stale data
        rdata <= !output_enable_n ? mem_r[adr_r] : ~rdata;
    end
endmodule

// File: tb/testbench.sv
/* Self-checking bench: write/read through every latency and mode, peripheral accesses, stall.
   Assumes the memory model stands on the pins and both interface clocks run at 160 ns. */
`timescale 1ns/100ps
`include "smp_defines.vh"
module testbench;
    reg                mclk, rst_b, ck_one, ck_two, req_valid, req_write, req_periph, rd_ready;
    reg                ext, mode, csel, cke_req, stall;
    reg [1:0]          rl, wl, prd, pwd;
    reg [3:0]          be;
    reg [`SMP_AW-1:0]  addr;
    reg [`SMP_DW-1:0]  wdata, d;
    reg [`SMP_DW-1:0]  shadow [0:15];
    reg [`SMP_DW-1:0]  exp_q [$];
    wire               req_ready_r, rd_valid_r, cs_n, strb_n, oe_n, we_n, d_oe;
    wire [`SMP_AW-1:0] m_addr;
    wire [`SMP_DW-1:0] rd_data_r, d_out, d_in;
    integer            n_mismatch, total_checks, cyc, i, k;

    smp_ctrl #(.FIRST_PORT(1)) dut (.mclk(mclk), .rst_b(rst_b), .interface_clock_one(ck_one),
        .interface_clock_two(ck_two), .sync_read_latency(rl), .sync_write_latency(wl),
        .chip_select_extend(ext), .read_enable_mode(mode), .sync_clock_select(csel),
        .peripheral_read_delay(prd), .peripheral_write_delay(pwd),
        .sdram_clock_enable_req(cke_req), .req_valid(req_valid), .req_ready_r(req_ready_r),
        .req_write(req_write), .req_periph(req_periph), .req_addr(addr), .req_be(be),
        .req_wdata(wdata), .rd_valid_r(rd_valid_r), .rd_ready(rd_ready), .rd_data_r(rd_data_r),
        .busy_r(), .chip_select_n_r(cs_n), .strobe_ads_re_n_r(strb_n),
        .sync_output_enable_n_r(oe_n), .sync_write_enable_n_r(we_n), .mem_addr_r(m_addr),
        .mem_be_n_r(), .mem_data_out_r(d_out), .mem_data_oe_r(d_oe), .mem_data_in(d_in),
        .peripheral_transfer_strobe_r(), .sdram_clock_enable_r());
    smp_mem_model u_mem (.mclk(mclk), .chip_select_n(cs_n), .output_enable_n(oe_n),
        .data_oe(d_oe), .addr(m_addr), .wdata(d_out), .rdata(d_in));

    // clocks: link clocks free running, phases unrelated to mclk and each other
    initial
    begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end
    initial
    begin
        ck_one = 1'b0;
        #7;
        forever #80 ck_one = ~ck_one;
    end
    initial
    begin
        ck_two = 1'b0;
        #43;
        forever #80 ck_two = ~ck_two;
    end

    task stop_test;
        begin
            $display("checks %0d mismatches %0d", total_checks, n_mismatch);
            if (n_mismatch == 0 && total_checks > 0)
                $display("ALL TESTS PASSED");
            else
                $display("TESTS FAILED");
            $finish;
        end
    endtask

    task chk_word(input reg [`SMP_DW-1:0] got);
        begin
            total_checks = total_checks + 1;
            if (exp_q.size() == 0 || got !== exp_q[0])
            begin
                n_mismatch = n_mismatch + 1;
                $display("BAD %0t read word %h", $time, got);
            end
            if (exp_q.size() != 0)
                void'(exp_q.pop_front());
        end
    endtask

    task chk_bit(input reg got, input reg want);
        begin
            total_checks = total_checks + 1;
            if (got !== want)
            begin
                n_mismatch = n_mismatch + 1;
                $display("BAD %0t flag %b", $time, got);
            end
        end
    endtask

    // one access: settings and request held from one edge until the accepting edge
    task access(input reg w, input reg p, input reg [5:0] cfg, input reg [3:0] a);
        begin
            d = $urandom;
            @(posedge mclk);
            {mode, ext, wl, rl} <= cfg;
            {csel, cke_req, prd, pwd} <= $urandom;
            be <= $urandom;
            {req_write, req_periph, addr, wdata, req_valid} <= {w, p, 16'h0000, a, d, 1'b1};
            if (w && !p)
                shadow[a] = d;
            if (!w && !p)
                exp_q.push_back(shadow[a]);
            k = 0;
            @(negedge mclk);
            while (req_ready_r !== 1'b1 && k < 3000)
            begin
                @(negedge mclk);
                k = k + 1;
            end
            // a request never taken is a failure, not a silent skip
            if (k >= 3000)
                n_mismatch = n_mismatch + 1;
            @(posedge mclk);
            req_valid <= 1'b0;
        end
    endtask

    // result watcher and receiver stalls
    always @(posedge mclk)
        if (rd_valid_r === 1'b1 && rd_ready === 1'b1)
            chk_word(rd_data_r);
    always @(posedge mclk)
        rd_ready <= !stall && ($urandom % 3 != 0);
    always @(posedge mclk)
    begin
        cyc = cyc + 1;
        if (cyc == 60000)
        begin
            n_mismatch = n_mismatch + 1;
            stop_test;
        end
    end

    initial
    begin
        {rst_b, req_valid, req_write, req_periph, ext, mode, csel, cke_req} = 8'h00;
        {rl, wl, prd, pwd, addr, wdata, stall, be} = 65'h0;
        {n_mismatch, total_checks, cyc} = 0;
        k = $urandom(45);
        repeat (6) @(posedge mclk);
        rst_b <= 1'b1;
        // every latency pair, select extension and strobe mode
        for (i = 0; i < 64; i = i + 1)
        begin
            access(1'b1, 1'b0, i[5:0], i[3:0]);
            access(1'b0, 1'b0, i[5:0], i[3:0]);
        end
        $display("test latency sweep done");
        // peripheral write leaves memory alone; peripheral read returns nothing
        for (i = 0; i < 4; i = i + 1)
        begin
            access(1'b1, 1'b1, $urandom, i[3:0]);
            access(1'b0, 1'b1, $urandom, i[3:0]);
            access(1'b0, 1'b0, $urandom, i[3:0]);
        end
        $display("test peripheral done");
        // stalled receiver: drain the last read first, so that exactly two
        // words fill the buffer and the next request is refused
        while (exp_q.size() != 0)
            @(posedge mclk);
        stall <= 1'b1;
        access(1'b0, 1'b0, 6'h00, 4'h5);
        access(1'b0, 1'b0, 6'h23, 4'h6);
        repeat (100) @(posedge mclk);
        chk_bit(req_ready_r, 1'b0);
        stall <= 1'b0;
        access(1'b0, 1'b0, 6'h11, 4'h7);
        k = 0;
        while (exp_q.size() != 0 && k < 500)
        begin
            @(posedge mclk);
            k = k + 1;
        end
        @(negedge mclk);
        chk_bit(rd_valid_r, 1'b0);
        chk_bit(exp_q.size() == 0, 1'b1);
        $display("test stall done");
        stop_test;
    end
endmodule
